// File: tlb_pkg.sv
package tlb_pkg;

   // ----------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------
   localparam int ENTRIES  = 64;
   localparam int IDX_W    = 6;
   localparam int PAGE_W   = 22;
   localparam int OFFSET_W = 10;
   localparam int OWNER_W  = 8;
   localparam int ATTR_W   = 30;
   localparam int RA_W     = 36;
   localparam int SIDES    = 2;
   localparam int SIDE_FETCH = 0;
   localparam int SIDE_DATA  = 1;

   // ----------------------------------------------------------------
   // Register word layout (entry bit 0 is register bit 31)
   // ----------------------------------------------------------------
   localparam int W0_PAGE_LSB     = 10;
   localparam int W0_VALID_BIT    = 9;
   localparam int W0_SPACE_BIT    = 8;
   localparam int W0_SIZE_LSB     = 4;
   localparam int W0_PARITY_LSB   = 0;
   localparam int W1_PAGE_LSB     = 10;
   localparam int W1_PARITY_LSB   = 8;
   localparam int W1_EXT_LSB      = 0;
   localparam int W2_PARITY_LSB   = 30;
   localparam int W2_COHERENT_BIT = 10;
   localparam logic [OWNER_W-1:0] SHARED_OWNER = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE          = 3'h0,
      OP_READ          = 3'h1,
      OP_WRITE         = 3'h2,
      OP_SEARCH        = 3'h3,
      OP_VA_INVALIDATE = 3'h4,
      OP_SYNC          = 3'h5
   } op_code_type;

   typedef enum logic [1:0] {
      WORD_TAG   = 2'h0,
      WORD_XLATE = 2'h1,
      WORD_ATTR  = 2'h2
   } word_sel_type;

   typedef struct packed {
      logic [PAGE_W-1:0]  effective_page_number;
      logic               valid;
      logic               address_space_select;
      logic [3:0]         page_size;
      logic [3:0]         tag_word_parity;
      logic [OWNER_W-1:0] translation_owner_id;
      logic [PAGE_W-1:0]  real_page_number;
      logic [1:0]         word1_parity;
      logic [3:0]         extended_real_page_number;
      logic [ATTR_W-1:0]  attr;
      logic [1:0]         word2_parity;
   } tlb_entry_type;

   typedef struct packed {
      logic        req;
      logic        space;
      logic [31:0] ea;
   } xlate_req_type;

   typedef struct packed {
      logic            done;
      logic            miss;
      logic            coherent;
      logic [RA_W-1:0] ra;
   } xlate_resp_type;

   typedef struct packed {
      logic               valid;
      op_code_type        op;
      logic [IDX_W-1:0]   index;
      word_sel_type       sel;
      logic [31:0]        reg_word;
      logic [31:0]        ea;
      logic [OWNER_W-1:0] owner;
      logic               space;
   } mgmt_req_type;

   typedef struct packed {
      logic               done;
      logic               illegal;
      logic [31:0]        reg_word;
      logic [OWNER_W-1:0] owner;
      logic               search_hit;
      logic [IDX_W-1:0]   search_index;
   } mgmt_resp_type;

   // Upper n of the page-number bits take part, n = 22 - 2*size
   function automatic logic [PAGE_W-1:0] page_mask(input logic [3:0] size);
      logic [PAGE_W-1:0] low;
      low = (22'h1 << {size, 1'b0}) - 22'h1;
      return ~low;
   endfunction : page_mask

   function automatic logic size_legal(input logic [3:0] size);
      return (size <= 4'h5) || (size == 4'h7) || (size == 4'h9);
   endfunction : size_legal

endpackage : tlb_pkg

// File: unified_tlb.sv
`timescale 1ns/1ps
// Behaviour
// - Coherent attribute flagged on outgoing transfer only
// - Address invalidate op raises illegal instruction
// - Sync op completes with no effect
// - Eight page sizes, 1KB to 256MB, mixed
// - One 64-entry array serves fetch and data
// - Fetch and data one-entry shadows front main
// - Three writes load entry words, owner id
// - Three reads return entry words, owner id
// - Search op finds entry by address, context
// - Compare upper n page bits with address
// - Valid bit gates matching; tag write loads it
// - Entry space bit must equal access selector
// - Size field selects 4^size KB, legal set
// - Tag parity computed on write, read back
// - Owner id zero means shared page
// - Real page bits replace upper address bits
// - Word 1 parity computed, supplied bits ignored
// - Extended page bits prepended, 36-bit address
// - Word 2 parity computed, supplied bits ignored
// - No match raises translation error per side
module unified_tlb (
   input  logic                   clk_in,
   input  logic                   reset_in,
   input  tlb_pkg::mgmt_req_type  mgmt_in,
   output tlb_pkg::mgmt_resp_type mgmt_out,
   input  logic [7:0]             pid_in,
   input  tlb_pkg::xlate_req_type fetch_in,
   input  tlb_pkg::xlate_req_type data_in,
   output logic                   fetch_ready_out,
   output logic                   data_ready_out,
   output tlb_pkg::xlate_resp_type fetch_out,
   output tlb_pkg::xlate_resp_type data_out
);

   localparam int N  = tlb_pkg::ENTRIES;
   localparam int IW = tlb_pkg::IDX_W;
   localparam int PL = tlb_pkg::OFFSET_W;
   localparam int PW = tlb_pkg::PAGE_W;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] tag_par(input tlb_pkg::tlb_entry_type e);
      return {^e.effective_page_number[21:11], ^e.effective_page_number[10:0],
              ^{e.valid, e.address_space_select, e.page_size}, ^e.translation_owner_id};
   endfunction : tag_par

   function automatic logic [1:0] w1_par(input tlb_pkg::tlb_entry_type e);
      return {^e.real_page_number, ^e.extended_real_page_number};
   endfunction : w1_par

   function automatic logic [1:0] w2_par(input tlb_pkg::tlb_entry_type e);
      return {^e.attr[29:15], ^e.attr[14:0]};
   endfunction : w2_par

   function automatic logic entry_match(input tlb_pkg::tlb_entry_type e,
                                        input logic [31:0] ea,
                                        input logic space,
                                        input logic [7:0] owner);
      logic [PW-1:0] m;
      m = tlb_pkg::page_mask(e.page_size);
      return e.valid
             && tlb_pkg::size_legal(e.page_size)
             && (e.address_space_select == space)
             && ((e.translation_owner_id == tlb_pkg::SHARED_OWNER)
                 || (e.translation_owner_id == owner))
             && (((e.effective_page_number ^ ea[PL +: PW]) & m) == '0);
   endfunction : entry_match

   function automatic logic [35:0] real_addr(input tlb_pkg::tlb_entry_type e,
                                             input logic [31:0] ea);
      logic [PW-1:0] m;
      m = tlb_pkg::page_mask(e.page_size);
      return {e.extended_real_page_number,
              (e.real_page_number & m) | (ea[PL +: PW] & ~m),
              ea[PL-1:0]};
   endfunction : real_addr

   // ----------------------------------------------------------------
   // Storage and shared lookup port
   // ----------------------------------------------------------------
   tlb_pkg::tlb_entry_type  entry_ff [N];
   tlb_pkg::xlate_req_type  req_w    [tlb_pkg::SIDES];
   tlb_pkg::xlate_req_type  hold_w   [tlb_pkg::SIDES];
   tlb_pkg::xlate_req_type  lk_req_w;
   tlb_pkg::tlb_entry_type  main_sel_w;
   logic [1:0]              pend_w;
   logic [1:0]              gnt_w;
   logic [N-1:0]            main_hit_w;
   logic [N-1:0]            srch_hit_w;
   logic [IW-1:0]           main_idx_w;
   logic [IW-1:0]           srch_idx_w;
   logic                    main_any_w;
   logic                    srch_any_w;
   logic                    wr_w;
   logic                    rd_w;
   logic                    srch_w;
   logic                    inval_w;
   logic                    sync_w;

   assign req_w[tlb_pkg::SIDE_FETCH] = fetch_in;
   assign req_w[tlb_pkg::SIDE_DATA]  = data_in;
   assign fetch_ready_out = !pend_w[tlb_pkg::SIDE_FETCH];
   assign data_ready_out  = !pend_w[tlb_pkg::SIDE_DATA];

   // Data wins the main port; fetch waits at most one extra cycle since
   // a data miss cannot be pending two cycles in a row
   assign gnt_w[tlb_pkg::SIDE_DATA]  = pend_w[tlb_pkg::SIDE_DATA];
   assign gnt_w[tlb_pkg::SIDE_FETCH] = pend_w[tlb_pkg::SIDE_FETCH] && !pend_w[tlb_pkg::SIDE_DATA];
   assign lk_req_w = gnt_w[tlb_pkg::SIDE_DATA] ? hold_w[tlb_pkg::SIDE_DATA]
                                               : hold_w[tlb_pkg::SIDE_FETCH];

   for (genvar i = 0; i < N; i++) begin : g_cam
      assign main_hit_w[i] = entry_match(entry_ff[i], lk_req_w.ea, lk_req_w.space, pid_in);
      assign srch_hit_w[i] = entry_match(entry_ff[i], mgmt_in.ea, mgmt_in.space,
                                         mgmt_in.owner);
   end

   // Lowest index wins when software leaves overlapping entries
   always_comb begin
      main_idx_w = '0;
      srch_idx_w = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (main_hit_w[i]) begin
            main_idx_w = IW'(i);
         end
         if (srch_hit_w[i]) begin
            srch_idx_w = IW'(i);
         end
      end
   end

   assign main_any_w = |main_hit_w;
   assign srch_any_w = |srch_hit_w;
   assign main_sel_w = entry_ff[main_idx_w];

   // ----------------------------------------------------------------
   // Fetch and data sides with their shadow entries
   // ----------------------------------------------------------------
   for (genvar s = 0; s < tlb_pkg::SIDES; s++) begin : g_side
      logic                    pend_ff;
      logic                    take_w;
      logic                    sh_hit_w;
      tlb_pkg::xlate_req_type  hold_ff;
      tlb_pkg::xlate_resp_type resp_ff;
      tlb_pkg::xlate_resp_type nxt_resp;
      tlb_pkg::tlb_entry_type  shadow_ff;

      assign take_w    = req_w[s].req && !pend_ff;
      assign sh_hit_w  = entry_match(shadow_ff, req_w[s].ea, req_w[s].space, pid_in);
      assign pend_w[s] = pend_ff;
      assign hold_w[s] = hold_ff;

      always_comb begin
         nxt_resp = '0;
         if (take_w && sh_hit_w) begin
            nxt_resp.done     = 1'b1;
            nxt_resp.coherent = shadow_ff.attr[tlb_pkg::W2_COHERENT_BIT];
            nxt_resp.ra       = real_addr(shadow_ff, req_w[s].ea);
         end else if (gnt_w[s]) begin
            nxt_resp.done     = 1'b1;
            nxt_resp.miss     = !main_any_w;
            nxt_resp.coherent = main_any_w && main_sel_w.attr[tlb_pkg::W2_COHERENT_BIT];
            nxt_resp.ra       = main_any_w ? real_addr(main_sel_w, lk_req_w.ea) : '0;
         end
      end

      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            pend_ff   <= 1'b0;
            hold_ff   <= '0;
            resp_ff   <= '0;
            shadow_ff <= '0;
         end else begin
            resp_ff <= nxt_resp;
            if (take_w) begin
               hold_ff <= req_w[s];
            end
            if (gnt_w[s]) begin
               pend_ff <= 1'b0;
            end else if (take_w && !sh_hit_w) begin
               pend_ff <= 1'b1;
            end
            // A write beats a refill in the same cycle, so no stale copy survives
            if (wr_w) begin
               shadow_ff <= '0;
            end else if (gnt_w[s] && main_any_w) begin
               shadow_ff <= main_sel_w;
            end
         end
      end
   end

   assign fetch_out = g_side[tlb_pkg::SIDE_FETCH].resp_ff;
   assign data_out  = g_side[tlb_pkg::SIDE_DATA].resp_ff;

   // ----------------------------------------------------------------
   // Entry maintenance
   // ----------------------------------------------------------------
   tlb_pkg::tlb_entry_type  cur_w;
   tlb_pkg::tlb_entry_type  wr_entry_w;
   tlb_pkg::mgmt_resp_type  nxt_mgmt;
   tlb_pkg::mgmt_resp_type  mgmt_ff;
   logic [31:0]             rd_word_w;
   logic                    wr_legal_w;

   assign wr_w    = mgmt_in.valid && (mgmt_in.op == tlb_pkg::OP_WRITE);
   assign rd_w    = mgmt_in.valid && (mgmt_in.op == tlb_pkg::OP_READ);
   assign srch_w  = mgmt_in.valid && (mgmt_in.op == tlb_pkg::OP_SEARCH);
   assign inval_w = mgmt_in.valid && (mgmt_in.op == tlb_pkg::OP_VA_INVALIDATE);
   assign sync_w  = mgmt_in.valid && (mgmt_in.op == tlb_pkg::OP_SYNC);
   assign cur_w   = entry_ff[mgmt_in.index];
   assign wr_legal_w = wr_w && (mgmt_in.sel != 2'h3);

   // Supplied parity bits are dropped; fresh parity goes with each word
   always_comb begin
      wr_entry_w = cur_w;
      unique case (mgmt_in.sel)
         tlb_pkg::WORD_TAG: begin
            wr_entry_w.effective_page_number = mgmt_in.reg_word[tlb_pkg::W0_PAGE_LSB +: PW];
            wr_entry_w.valid                 = mgmt_in.reg_word[tlb_pkg::W0_VALID_BIT];
            wr_entry_w.address_space_select  = mgmt_in.reg_word[tlb_pkg::W0_SPACE_BIT];
            wr_entry_w.page_size             = mgmt_in.reg_word[tlb_pkg::W0_SIZE_LSB +: 4];
            wr_entry_w.translation_owner_id  = mgmt_in.owner;
            wr_entry_w.tag_word_parity       = tag_par(wr_entry_w);
         end
         tlb_pkg::WORD_XLATE: begin
            wr_entry_w.real_page_number          = mgmt_in.reg_word[tlb_pkg::W1_PAGE_LSB +: PW];
            wr_entry_w.extended_real_page_number = mgmt_in.reg_word[tlb_pkg::W1_EXT_LSB +: 4];
            wr_entry_w.word1_parity              = w1_par(wr_entry_w);
         end
         tlb_pkg::WORD_ATTR: begin
            wr_entry_w.attr         = mgmt_in.reg_word[tlb_pkg::ATTR_W-1:0];
            wr_entry_w.word2_parity = w2_par(wr_entry_w);
         end
         default: begin
            wr_entry_w = cur_w;
         end
      endcase
   end

   always_comb begin
      unique case (mgmt_in.sel)
         tlb_pkg::WORD_TAG: begin
            rd_word_w = {cur_w.effective_page_number, cur_w.valid, cur_w.address_space_select,
                         cur_w.page_size, cur_w.tag_word_parity};
         end
         tlb_pkg::WORD_XLATE: begin
            rd_word_w = {cur_w.real_page_number, cur_w.word1_parity, 4'h0,
                         cur_w.extended_real_page_number};
         end
         tlb_pkg::WORD_ATTR: begin
            rd_word_w = {cur_w.word2_parity, cur_w.attr};
         end
         default: begin
            rd_word_w = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      nxt_mgmt              = '0;
      nxt_mgmt.illegal      = inval_w;
      nxt_mgmt.done         = rd_w || wr_w || srch_w || sync_w;
      nxt_mgmt.reg_word     = rd_w ? rd_word_w : 32'h0000_0000;
      nxt_mgmt.owner        = (rd_w && (mgmt_in.sel == tlb_pkg::WORD_TAG))
                              ? cur_w.translation_owner_id : 8'h00;
      nxt_mgmt.search_hit   = srch_w && srch_any_w;
      nxt_mgmt.search_index = (srch_w && srch_any_w) ? srch_idx_w : '0;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         mgmt_ff <= '0;
         for (int i = 0; i < N; i++) begin
            entry_ff[i] <= '0;
         end
      end else begin
         mgmt_ff <= nxt_mgmt;
         if (wr_legal_w) begin
            entry_ff[mgmt_in.index] <= wr_entry_w;
         end
      end
   end

   assign mgmt_out = mgmt_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_fetch_miss;
      g_side[0].take_w && !g_side[0].sh_hit_w;
   endsequence
   sequence s_data_miss;
      g_side[1].take_w && !g_side[1].sh_hit_w;
   endsequence

   property p_fetch_miss_latency;
      s_fetch_miss |-> ##[2:3] fetch_out.done;
   endproperty
   a_fetch_miss_latency: assert property (p_fetch_miss_latency)
      else $error("fetch miss not answered in two or three cycles");

   property p_data_miss_latency;
      s_data_miss |-> ##2 data_out.done;
   endproperty
   a_data_miss_latency: assert property (p_data_miss_latency)
      else $error("data miss not answered in two cycles");

   property p_shadow_hit;
      g_side[0].take_w && g_side[0].sh_hit_w |=> fetch_out.done && !fetch_out.miss;
   endproperty
   a_shadow_hit: assert property (p_shadow_hit)
      else $error("fetch shadow hit not answered next cycle");

   property p_miss_error;
      gnt_w[1] && !main_any_w |=> data_out.done && data_out.miss && !fetch_out.miss;
   endproperty
   a_miss_error: assert property (p_miss_error)
      else $error("data miss did not raise a translation error");

   property p_coherent;
      gnt_w[1] && main_any_w |=>
         data_out.coherent == $past(main_sel_w.attr[tlb_pkg::W2_COHERENT_BIT]);
   endproperty
   a_coherent: assert property (p_coherent)
      else $error("coherent attribute not passed to transfer");

   property p_ext_page;
      gnt_w[1] && main_any_w |=> data_out.ra[35:32] == $past(main_sel_w.extended_real_page_number);
   endproperty
   a_ext_page: assert property (p_ext_page)
      else $error("extended page bits not prepended");

   property p_va_invalidate;
      inval_w |=> mgmt_out.illegal && !mgmt_out.done;
   endproperty
   a_va_invalidate: assert property (p_va_invalidate)
      else $error("invalidate op did not raise illegal instruction");

   property p_sync;
      sync_w && !gnt_w[0] |=> mgmt_out.done && !mgmt_out.illegal && $stable(g_side[0].shadow_ff);
   endproperty
   a_sync: assert property (p_sync)
      else $error("sync op had an effect");

   property p_write_clears_shadow;
      wr_w |=> !g_side[0].shadow_ff.valid && !g_side[1].shadow_ff.valid;
   endproperty
   a_write_clears_shadow: assert property (p_write_clears_shadow)
      else $error("shadow survived an entry write");

   property p_tag_parity;
      wr_w && (mgmt_in.sel == tlb_pkg::WORD_TAG) |=>
         entry_ff[$past(mgmt_in.index)].tag_word_parity
            == tag_par(entry_ff[$past(mgmt_in.index)]);
   endproperty
   a_tag_parity: assert property (p_tag_parity)
      else $error("tag parity not computed on write");

   property p_write_valid;
      wr_w && (mgmt_in.sel == tlb_pkg::WORD_TAG) |=>
         entry_ff[$past(mgmt_in.index)].valid == $past(mgmt_in.reg_word[tlb_pkg::W0_VALID_BIT]);
   endproperty
   a_write_valid: assert property (p_write_valid)
      else $error("valid bit not taken from written word");

   property p_read_owner;
      rd_w && (mgmt_in.sel == tlb_pkg::WORD_TAG) |=>
         mgmt_out.owner == $past(cur_w.translation_owner_id);
   endproperty
   a_read_owner: assert property (p_read_owner)
      else $error("owner id not returned on tag read");

   property p_space;
      main_any_w |-> main_sel_w.address_space_select == lk_req_w.space;
   endproperty
   a_space: assert property (p_space)
      else $error("entry matched in the wrong address space");

endmodule : unified_tlb

// File: xlate_requester.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One pipeline side: a single request, held until taken
// ----------------------------------------------------------------
module xlate_requester (
   input  wire logic                    clk_in,
   input  wire logic                    ready_in,
   input  wire tlb_pkg::xlate_resp_type resp_in,
   output tlb_pkg::xlate_req_type       req_out
);
   tlb_pkg::xlate_resp_type got_resp;

   initial req_out = '0;

   task automatic issue(input logic space, input logic [31:0] ea);
      int n;
      n = 0;
      // Let an edge pass so a release and a new request never share a step
      @(posedge clk_in);
      #1;
      req_out = {1'b1, space, ea};
      while (ready_in !== 1'b1 && n < 8) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      @(posedge clk_in);
      #1;
      // Released lines show the inverse, so a stale address cannot pass
      req_out = {1'b0, ~space, ~ea};
      n = 0;
      while (resp_in.done !== 1'b1 && n < 4) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      got_resp = resp_in;
   endtask : issue
endmodule : xlate_requester

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                    clk_in   = 1'b0;
   logic                    reset_in = 1'b1;
   logic [7:0]              pid_in   = 8'h00;
   tlb_pkg::mgmt_req_type   mgmt     = '0;
   tlb_pkg::mgmt_resp_type  resp, got;
   tlb_pkg::xlate_req_type  fetch_req, data_req;
   tlb_pkg::xlate_resp_type fetch_resp, data_resp, got_x;
   logic                    fetch_ready, data_ready;
   int                      mismatches = 0;
   int                      checked    = 0;
   int                      cycles     = 0;
   logic [3:0]              sizes [9]  = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'h6};
   logic [31:0]             mask, ea;
   logic [7:0]              par_a, par_b;

   always #2 clk_in = ~clk_in;

   unified_tlb i_dut (.clk_in(clk_in), .reset_in(reset_in), .mgmt_in(mgmt), .mgmt_out(resp),
      .pid_in(pid_in), .fetch_in(fetch_req), .data_in(data_req), .fetch_ready_out(fetch_ready),
      .data_ready_out(data_ready), .fetch_out(fetch_resp), .data_out(data_resp));
   xlate_requester i_fetch (.clk_in(clk_in), .ready_in(fetch_ready), .resp_in(fetch_resp),
      .req_out(fetch_req));
   xlate_requester i_data (.clk_in(clk_in), .ready_in(data_ready), .resp_in(data_resp),
      .req_out(data_req));

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic mop(input tlb_pkg::op_code_type op, input logic [1:0] sel,
                      input logic [5:0] idx, input logic [31:0] w, input logic [7:0] own,
                      input logic [31:0] a = 32'h0, input logic sp = 1'b0);
      int n;
      n = 0;
      // One idle edge between ops, so valid is never set twice in one step
      @(posedge clk_in);
      #1;
      mgmt = '{1'b1, op, idx, tlb_pkg::word_sel_type'(sel), w, a, own, sp};
      @(posedge clk_in);
      #1;
      mgmt.valid = 1'b0;
      while ((resp.done | resp.illegal) !== 1'b1 && n < 3) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      got = resp;
      if (op != tlb_pkg::OP_VA_INVALIDATE) chk("done", 36'h1, got.done);
   endtask : mop

   task automatic wr_entry(input logic [5:0] i, input logic [31:0] w0, w1, w2,
                           input logic [7:0] own);
      mop(tlb_pkg::OP_WRITE, 2'h0, i, w0, own);
      mop(tlb_pkg::OP_WRITE, 2'h1, i, w1, own);
      mop(tlb_pkg::OP_WRITE, 2'h2, i, w2, own);
   endtask : wr_entry

   // Parity bits are masked off and handed back for comparison
   task automatic rd_entry(input logic [5:0] i, input logic [31:0] w0, w1, w2,
                           input logic [7:0] own, output logic [7:0] par);
      mop(tlb_pkg::OP_READ, 2'h0, i, 32'h0, 8'h00);
      chk("word0", w0 & 32'hFFFFFFF0, got.reg_word & 32'hFFFFFFF0);
      chk("owner", own, got.owner);
      par[7:4] = got.reg_word[3:0];
      mop(tlb_pkg::OP_READ, 2'h1, i, 32'h0, 8'h00);
      chk("word1", w1 & 32'hFFFFFCFF, got.reg_word & 32'hFFFFFCFF);
      par[3:2] = got.reg_word[9:8];
      mop(tlb_pkg::OP_READ, 2'h2, i, 32'h0, 8'h00);
      chk("word2", w2 & 32'h3FFFFFFF, got.reg_word & 32'h3FFFFFFF);
      par[1:0] = got.reg_word[31:30];
   endtask : rd_entry

   task automatic xl(input logic dside, input logic sp, input logic [31:0] a,
                     input logic miss, input logic [35:0] ra);
      if (dside) i_data.issue(sp, a);
      else i_fetch.issue(sp, a);
      got_x = dside ? i_data.got_resp : i_fetch.got_resp;
      chk("xdone", 36'h1, got_x.done);
      chk("miss", miss, got_x.miss);
      if (!miss) chk("ra", ra, got_x.ra);
   endtask : xl

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      chk("ready", 36'h1, fetch_ready & data_ready);
      // Supplied parity bits set, then cleared: stored parity must not follow them
      wr_entry(6'h03, 32'h1234521F, 32'hABCDE305, 32'hC0000400, 8'h00);
      rd_entry(6'h03, 32'h12345210, 32'hABCDE005, 32'h00000400, 8'h00, par_a);
      wr_entry(6'h03, 32'h12345210, 32'hABCDE005, 32'h00000400, 8'h00);
      rd_entry(6'h03, 32'h12345210, 32'hABCDE005, 32'h00000400, 8'h00, par_b);
      chk("parity", par_a, par_b);
      xl(1'b1, 1'b0, 32'h12345678, 1'b0, 36'h5ABCDE678);
      chk("coherent", 36'h1, got_x.coherent);
      xl(1'b1, 1'b0, 32'h12345678, 1'b0, 36'h5ABCDE678);
      xl(1'b0, 1'b0, 32'h12345ABC, 1'b0, 36'h5ABCDEABC);
      xl(1'b0, 1'b1, 32'h12345678, 1'b1, 36'h0);
      wr_entry(6'h04, 32'h40000300, 32'h80000400, 32'h0, 8'h07);
      pid_in = 8'h07;
      xl(1'b1, 1'b1, 32'h40000123, 1'b0, 36'h080000523);
      chk("coherent", 36'h0, got_x.coherent);
      pid_in = 8'h08;
      xl(1'b1, 1'b1, 32'h40000123, 1'b1, 36'h0);
      mop(tlb_pkg::OP_SEARCH, 2'h0, 6'h00, 32'h0, 8'h07, 32'h40000123, 1'b1);
      chk("hit", 36'h1, got.search_hit);
      chk("index", 36'h4, got.search_index);
      mop(tlb_pkg::OP_SEARCH, 2'h0, 6'h00, 32'h0, 8'h00, 32'h40000123, 1'b1);
      chk("hit", 36'h0, got.search_hit);
      mop(tlb_pkg::OP_SEARCH, 2'h0, 6'h00, 32'h0, 8'h09, 32'h12345678, 1'b0);
      chk("index", 36'h3, got.search_index);
      mop(tlb_pkg::OP_VA_INVALIDATE, 2'h0, 6'h04, 32'h0, 8'h00);
      chk("illegal", 36'h2, {got.illegal, got.done});
      mop(tlb_pkg::OP_SYNC, 2'h0, 6'h04, 32'h0, 8'h00);
      pid_in = 8'h07;
      xl(1'b1, 1'b1, 32'h40000123, 1'b0, 36'h080000523);
      xl(1'b0, 1'b0, 32'h12345678, 1'b0, 36'h5ABCDE678);
      // Invalidate by rewrite; the fetch shadow copy must go as well
      wr_entry(6'h03, 32'h12345010, 32'hABCDE005, 32'h0, 8'h00);
      xl(1'b0, 1'b0, 32'h12345678, 1'b1, 36'h0);
      mop(tlb_pkg::OP_WRITE, 2'h1, 6'h05, 32'h30000001, 8'h00);
      for (int i = 0; i < 9; i++) begin
         mask = (32'h1 << (10 + 2 * sizes[i])) - 32'h1;
         ea = 32'hF0000000 | (mask & 32'h05555555);
         mop(tlb_pkg::OP_WRITE, 2'h0, 6'h05, 32'hF0000200 | {sizes[i], 4'h0}, 8'h00);
         xl(1'b1, 1'b0, ea, i == 8, {4'h1, 32'h30000000 | (ea & mask)});
         xl(1'b0, 1'b0, ea ^ (mask + 32'h1), 1'b1, 36'h0);
      end
      test_done();
   end
endmodule : testbench
